/* File: rtl/csi_counter_consts.svh */
`ifndef CSI_COUNTER_CONSTS_SVH
`define CSI_COUNTER_CONSTS_SVH

// ----------------------------------------------------------------------
// Register indices; the byte address is four times the index
// ----------------------------------------------------------------------
`define IDX_P0_BAD_LINES_HIGH   10'h096
`define IDX_P0_BAD_LINES_LOW    10'h097
`define IDX_P1_FRAMES_HIGH      10'h098
`define IDX_P1_FRAMES_LOW       10'h099
`define IDX_P1_BAD_FRAMES_HIGH  10'h09A
`define IDX_P1_BAD_FRAMES_LOW   10'h09B
`define IDX_P1_LINES_HIGH       10'h09C
`define IDX_P1_LINES_LOW        10'h09D
`define IDX_P1_BAD_LINES_HIGH   10'h09E
`define IDX_P1_BAD_LINES_LOW    10'h09F
`define IDX_IRQ_STATUS          10'h0C0
`define IDX_IRQ_MASK            10'h0C1

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define CNT_HIGH_MSB            15
`define CNT_HIGH_LSB            8
`define CNT_LOW_MSB             7
`define CNT_LOW_LSB             0
`define CNT_RESET               16'h0000
`define SNAP_RESET              8'h00
`define IRQ_MASK_RESET          5'h00
`define IRQ_STATUS_RESET        5'h00
`define NUM_COUNTERS            5

// Counter slots inside the event and status vectors
`define SLOT_P0_BAD_LINES       0
`define SLOT_P1_FRAMES          1
`define SLOT_P1_BAD_FRAMES      2
`define SLOT_P1_LINES           3
`define SLOT_P1_BAD_LINES       4

`endif

/* File: rtl/csi_counter_pkg.sv */
`default_nettype none

package csi_counter_pkg;

	// ------------------------------------------------------------------
	// Types shared by the counter bank
	// ------------------------------------------------------------------
	typedef logic [15:0] count_t;
	typedef logic [7:0]  byte_t;

	// Which register an APB address selects
	typedef enum logic [3:0] {
		SEL_NONE       = 4'h0,
		SEL_CNT_HIGH   = 4'h1,
		SEL_CNT_LOW    = 4'h2,
		SEL_IRQ_STATUS = 4'h3,
		SEL_IRQ_MASK   = 4'h4
	} reg_sel_t;

endpackage

`default_nettype wire

/* File: rtl/snapshot_counter.sv */
`timescale 1ns/1ns
`default_nettype none
`include "csi_counter_consts.svh"

module snapshot_counter (
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	input  wire logic                   count_en,
	input  wire logic                   read_high,
	output logic [7:0]                  high_byte,
	output logic [7:0]                  low_byte,
	output logic                        wrapped
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	csi_counter_pkg::count_t count_ff;   // Live 16-bit count
	csi_counter_pkg::count_t nxt_count;  // Next count
	csi_counter_pkg::byte_t  snap_ff;    // Low byte caught by high read
	csi_counter_pkg::count_t count_inc;  // Count plus one, wraps

	assign count_inc = count_ff + 16'h0001; // R09
	assign high_byte = count_ff[`CNT_HIGH_MSB:`CNT_HIGH_LSB]; // R01
	// A high read in the same cycle restarts at one, so that is no wrap
	assign wrapped   = count_en && !read_high && (count_ff == 16'hFFFF);

	// ------------------------------------------------------------------
	// Next count: a high read clears, an increment in that same
	// cycle is kept so no unit is lost across the read
	// ------------------------------------------------------------------
	always_comb begin
		if (read_high) begin
			nxt_count = count_en ? 16'h0001 : `CNT_RESET; // R02 R09
		end else if (count_en) begin
			nxt_count = count_inc; // R09
		end else begin
			nxt_count = count_ff;
		end
	end

	// Counter register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_ff <= `CNT_RESET;
		end else begin
			count_ff <= nxt_count;
		end
	end

	// Snapshot of the low byte, taken only on a high read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			snap_ff <= `SNAP_RESET;
		end else if (read_high) begin
			snap_ff <= count_ff[`CNT_LOW_MSB:`CNT_LOW_LSB]; // R02
		end
	end

	assign low_byte = snap_ff; // R07

endmodule

`default_nettype wire

/* File: rtl/csi_output_frame_line_counters.sv */
// Notes on behaviour
// R01: Port 1 frames count; high read gives 15:8
// R02: High read snapshots low byte, then clears count
// R03: Software reads high byte before low byte
// R04: Port 1 bad frames count, same read behaviour
// R05: Port 1 lines count, same read behaviour
// R06: Port 1 bad lines count, same read behaviour
// R07: Port 0 bad lines low returns snapshot only
// R08: Port 0 bad lines high read snapshots, clears
// R09: Count one per unit, wrap, reads atomic
`timescale 1ns/1ns
`default_nettype none
`include "csi_counter_consts.svh"

module csi_output_frame_line_counters (
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	// APB slave
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [11:0]            paddr,
	input  wire logic [31:0]            pwdata,
	input  wire logic [3:0]             pstrb,
	output logic                        pready,
	output logic [31:0]                 prdata,
	output logic                        pslverr,
	// Unit events from the output ports, one-cycle pulses
	input  wire logic                   port0_line_bad,
	input  wire logic                   port1_frame_done,
	input  wire logic                   port1_frame_bad,
	input  wire logic                   port1_line_done,
	input  wire logic                   port1_line_bad,
	// Interrupt
	output logic                        irq
);

	// ------------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------------

	// Map a word index to the kind of register it selects
	function automatic csi_counter_pkg::reg_sel_t decode_sel(
		input logic [9:0] idx
	);
		csi_counter_pkg::reg_sel_t sel;
		sel = csi_counter_pkg::SEL_NONE;
		unique case (idx)
			`IDX_P0_BAD_LINES_HIGH,
			`IDX_P1_FRAMES_HIGH,
			`IDX_P1_BAD_FRAMES_HIGH,
			`IDX_P1_LINES_HIGH,
			`IDX_P1_BAD_LINES_HIGH: begin
				sel = csi_counter_pkg::SEL_CNT_HIGH;
			end
			`IDX_P0_BAD_LINES_LOW,
			`IDX_P1_FRAMES_LOW,
			`IDX_P1_BAD_FRAMES_LOW,
			`IDX_P1_LINES_LOW,
			`IDX_P1_BAD_LINES_LOW: begin
				sel = csi_counter_pkg::SEL_CNT_LOW;
			end
			`IDX_IRQ_STATUS: begin
				sel = csi_counter_pkg::SEL_IRQ_STATUS;
			end
			`IDX_IRQ_MASK: begin
				sel = csi_counter_pkg::SEL_IRQ_MASK;
			end
			default: begin
				sel = csi_counter_pkg::SEL_NONE;
			end
		endcase
		return sel;
	endfunction

	// Map a counter register index to its counter slot
	function automatic logic [2:0] decode_slot(input logic [9:0] idx);
		logic [2:0] slot;
		slot = 3'h0;
		unique case (idx)
			`IDX_P0_BAD_LINES_HIGH,
			`IDX_P0_BAD_LINES_LOW: begin
				slot = 3'(`SLOT_P0_BAD_LINES);
			end
			`IDX_P1_FRAMES_HIGH,
			`IDX_P1_FRAMES_LOW: begin
				slot = 3'(`SLOT_P1_FRAMES);
			end
			`IDX_P1_BAD_FRAMES_HIGH,
			`IDX_P1_BAD_FRAMES_LOW: begin
				slot = 3'(`SLOT_P1_BAD_FRAMES);
			end
			`IDX_P1_LINES_HIGH,
			`IDX_P1_LINES_LOW: begin
				slot = 3'(`SLOT_P1_LINES);
			end
			`IDX_P1_BAD_LINES_HIGH,
			`IDX_P1_BAD_LINES_LOW: begin
				slot = 3'(`SLOT_P1_BAD_LINES);
			end
			default: begin
				slot = 3'h0;
			end
		endcase
		return slot;
	endfunction

	// ------------------------------------------------------------------
	// Bus phase tracking
	// ------------------------------------------------------------------
	logic                        ack_ff;      // Second access cycle
	logic                        nxt_ack;     // Next acknowledge state
	logic                        access_take; // Edge that acts on request
	logic [9:0]                  word_idx;    // Word index from paddr
	csi_counter_pkg::reg_sel_t   sel;         // Selected register kind
	logic [2:0]                  slot;        // Selected counter slot
	logic                        rd_take;     // Read acted on this edge
	logic                        wr_take;     // Write acted on this edge
	logic                        bad_addr;    // No register at address

	assign word_idx    = paddr[11:2];
	assign sel         = decode_sel(word_idx);
	assign slot        = decode_slot(word_idx);
	assign bad_addr    = (sel == csi_counter_pkg::SEL_NONE);
	// First access cycle: side effects and read data capture happen here
	assign access_take = psel && penable && !ack_ff;
	assign rd_take     = access_take && !pwrite;
	assign wr_take     = access_take && pwrite;
	assign nxt_ack     = access_take;

	// One wait state, so read data comes from a flip-flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= nxt_ack;
		end
	end

	// ------------------------------------------------------------------
	// Counter bank
	// ------------------------------------------------------------------
	logic [`NUM_COUNTERS-1:0]    cnt_event;   // Unit events per slot
	logic [`NUM_COUNTERS-1:0]    cnt_rd_high; // High-byte read per slot
	logic [`NUM_COUNTERS-1:0]    cnt_wrap;    // Wrap pulse per slot
	logic [7:0]                  cnt_high [`NUM_COUNTERS]; // Upper bytes
	logic [7:0]                  cnt_low  [`NUM_COUNTERS]; // Snapshots

	// Event inputs packed by slot
	assign cnt_event[`SLOT_P0_BAD_LINES]  = port0_line_bad;   // R08
	assign cnt_event[`SLOT_P1_FRAMES]     = port1_frame_done; // R01
	assign cnt_event[`SLOT_P1_BAD_FRAMES] = port1_frame_bad;  // R04
	assign cnt_event[`SLOT_P1_LINES]      = port1_line_done;  // R05
	assign cnt_event[`SLOT_P1_BAD_LINES]  = port1_line_bad;   // R06

	// A low-byte read never reaches the counter, so it does not clear
	genvar gi;
	generate
		for (gi = 0; gi < `NUM_COUNTERS; gi++) begin : g_cnt
			// High-byte read strobe for this slot
			assign cnt_rd_high[gi] = rd_take &&
				(sel == csi_counter_pkg::SEL_CNT_HIGH) &&
				(slot == 3'(gi)); // R02 R04 R05 R06 R08

			// One snapshot counter per slot
			snapshot_counter u_cnt (
				.pclk      (pclk),
				.presetn   (presetn),
				.count_en  (cnt_event[gi]),
				.read_high (cnt_rd_high[gi]),
				.high_byte (cnt_high[gi]),
				.low_byte  (cnt_low[gi]),
				.wrapped   (cnt_wrap[gi])
			);
		end
	endgenerate

	// ------------------------------------------------------------------
	// Interrupts: a counter wrap sets a sticky status bit
	// ------------------------------------------------------------------
	logic [`NUM_COUNTERS-1:0]    irq_status_ff;  // Sticky wrap flags
	logic [`NUM_COUNTERS-1:0]    nxt_irq_status; // Next status
	logic [`NUM_COUNTERS-1:0]    irq_mask_ff;    // Enable per flag
	logic                        status_rd;      // Status read clears
	logic                        mask_wr;        // Mask write strobe

	assign status_rd = rd_take && (sel == csi_counter_pkg::SEL_IRQ_STATUS);
	assign mask_wr   = wr_take && (sel == csi_counter_pkg::SEL_IRQ_MASK) &&
		pstrb[0];
	// A wrap in the clearing cycle survives the read
	assign nxt_irq_status = (status_rd ? '0 : irq_status_ff) | cnt_wrap;

	// Sticky status
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status_ff <= `IRQ_STATUS_RESET;
		end else begin
			irq_status_ff <= nxt_irq_status;
		end
	end

	// Mask register, written through byte lane 0
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask_ff <= `IRQ_MASK_RESET;
		end else if (mask_wr) begin
			irq_mask_ff <= pwdata[`NUM_COUNTERS-1:0];
		end
	end

	// Level interrupt while any unmasked flag stands
	assign irq = |(irq_status_ff & irq_mask_ff);

	// ------------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------------
	logic [7:0]                  rd_byte;     // Selected register value
	logic [31:0]                 prdata_ff;   // Captured read data
	logic [31:0]                 nxt_prdata;  // Next read data
	logic                        pslverr_ff;  // Captured error answer
	logic                        nxt_pslverr; // Next error answer

	// Select the byte to return; counter bytes sit in the low lane
	always_comb begin
		rd_byte = 8'h00;
		unique case (sel)
			csi_counter_pkg::SEL_CNT_HIGH: begin
				rd_byte = cnt_high[slot]; // R01 R04 R05 R06 R08
			end
			csi_counter_pkg::SEL_CNT_LOW: begin
				rd_byte = cnt_low[slot]; // R03 R07
			end
			csi_counter_pkg::SEL_IRQ_STATUS: begin
				rd_byte = {3'h0, irq_status_ff};
			end
			csi_counter_pkg::SEL_IRQ_MASK: begin
				rd_byte = {3'h0, irq_mask_ff};
			end
			csi_counter_pkg::SEL_NONE: begin
				rd_byte = 8'h00;
			end
		endcase
	end

	assign nxt_prdata  = rd_take ? {24'h000000, rd_byte} : prdata_ff;
	// Unmapped addresses and writes to read-only registers fail
	assign nxt_pslverr = access_take ? (bad_addr ||
		(pwrite && (sel != csi_counter_pkg::SEL_IRQ_MASK))) : pslverr_ff;

	// Read data and error answer, held through the ready cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff  <= 32'h00000000;
			pslverr_ff <= 1'b0;
		end else begin
			prdata_ff  <= nxt_prdata;
			pslverr_ff <= nxt_pslverr;
		end
	end

	assign pready  = ack_ff;
	assign prdata  = prdata_ff;
	assign pslverr = ack_ff && pslverr_ff;

endmodule

`default_nettype wire

/* File: testbench/csi_counters_checker.sv */
`timescale 1ns/1ns
`default_nettype none
`include "csi_counter_consts.svh"

module csi_counters_checker (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic        pready,
	input  wire logic [31:0] prdata,
	input  wire logic        pslverr,
	input  wire logic        port0_line_bad,
	input  wire logic        port1_frame_done,
	input  wire logic        port1_frame_bad,
	input  wire logic        port1_line_done,
	input  wire logic        port1_line_bad,
	input  wire logic        irq
);
	// ------------------------------------------------------------
	// Shadow counters
	// ------------------------------------------------------------
	logic [4:0]  ev;        // Events in slot order
	logic [9:0]  idx;       // Word index
	logic [3:0]  off;       // Offset from first counter register
	logic [2:0]  slot;      // Counter slot
	logic        cnt_rd;    // Counter read taken this edge
	logic [15:0] sh_ff [5]; // Expected counts
	logic [7:0]  sn_ff [5]; // Expected snapshots
	logic [7:0]  exp_ff;    // Expected read byte
	assign ev = {port1_line_bad, port1_line_done, port1_frame_bad,
		port1_frame_done, port0_line_bad};
	assign idx = paddr[11:2];
	assign off = 4'(idx - `IDX_P0_BAD_LINES_HIGH);
	assign slot = off[3:1];
	assign cnt_rd = psel && penable && !pready && !pwrite &&
		idx >= `IDX_P0_BAD_LINES_HIGH && idx <= `IDX_P1_BAD_LINES_LOW;

	// A high read snapshots and restarts; an event on that edge counts
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 5; i++) begin
				sh_ff[i] <= 16'h0000;
				sn_ff[i] <= 8'h00;
			end
			exp_ff <= 8'h00;
		end else begin
			for (int i = 0; i < 5; i++) begin
				if (cnt_rd && slot == 3'(i) && !off[0]) begin
					sh_ff[i] <= {15'h0000, ev[i]};
					sn_ff[i] <= sh_ff[i][7:0];
				end else begin
					sh_ff[i] <= sh_ff[i] + {15'h0000, ev[i]};
				end
			end
			exp_ff <= off[0] ? sn_ff[slot] : sh_ff[slot][15:8];
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property rd_p(int s, bit lo);
		cnt_rd && slot == s && off[0] == lo
			|=> pready && !pslverr && prdata == {24'h000000, exp_ff};
	endproperty

	ack_wait_a: assert property (psel && penable && !pready |=> pready)
		else $error("no answer one cycle after access");
	p1_frames_hi_a: assert property (rd_p(1, 1'b0))
		else $error("port1 frames high byte wrong");
	p1_frames_lo_a: assert property (rd_p(1, 1'b1))
		else $error("port1 frames snapshot wrong");
	p1_badfr_hi_a: assert property (rd_p(2, 1'b0))
		else $error("port1 bad frames high byte wrong");
	p1_lines_hi_a: assert property (rd_p(3, 1'b0))
		else $error("port1 lines high byte wrong");
	p1_badln_hi_a: assert property (rd_p(4, 1'b0))
		else $error("port1 bad lines high byte wrong");
	p0_lines_lo_a: assert property (rd_p(0, 1'b1))
		else $error("port0 bad lines snapshot wrong");
	p0_lines_hi_a: assert property (rd_p(0, 1'b0))
		else $error("port0 bad lines high byte wrong");
	p1_badln_lo_a: assert property (rd_p(4, 1'b1))
		else $error("port1 bad lines snapshot wrong");

	cover property (cnt_rd && !off[0] && sh_ff[slot] > 16'h00FF);
	cover property (pready && pslverr);
	cover property (irq);
endmodule

bind csi_output_frame_line_counters csi_counters_checker chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pready(pready), .prdata(prdata),
	.pslverr(pslverr), .port0_line_bad(port0_line_bad),
	.port1_frame_done(port1_frame_done), .port1_frame_bad(port1_frame_bad),
	.port1_line_done(port1_line_done), .port1_line_bad(port1_line_bad),
	.irq(irq));
`default_nettype wire

/* File: testbench/csi_output_frame_line_counters_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
`include "csi_counter_consts.svh"

module csi_output_frame_line_counters_tb_top;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [3:0]  pstrb = 4'hF;
	logic [4:0]  ev = 5'h00;   // Event pulses in slot order
	logic        pready;
	logic [31:0] prdata;
	logic        pslverr;
	logic        irq;
	logic [32:0] exp_q [$];    // Expected {pslverr, prdata}
	int          error_cnt = 0;
	int          samples_checked = 0;
	int          n;

	always #10 pclk = ~pclk;

	csi_output_frame_line_counters DUT (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.pready(pready), .prdata(prdata), .pslverr(pslverr),
		.port0_line_bad(ev[0]), .port1_frame_done(ev[1]),
		.port1_frame_bad(ev[2]), .port1_line_done(ev[3]),
		.port1_line_bad(ev[4]), .irq(irq));

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	// Compare and count
	task automatic check(input logic [32:0] seen, input logic [32:0] want);
		samples_checked++;
		if (seen !== want) begin
			error_cnt++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, want);
		end
	endtask

	// One APB transfer; the result is noted for the monitor
	task automatic apb(input logic w, input logic [9:0] i,
		input logic [31:0] d, input logic [32:0] e);
		exp_q.push_back(e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {i, 2'b00};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk iff pready === 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	// Read expecting a byte and no error
	task automatic rd(input logic [9:0] i, input logic [7:0] e);
		apb(1'b0, i, 32'h00000000, {25'h0000000, e});
	endtask

	// Hold one event high for k cycles
	task automatic burst(input int s, input int k);
		ev[s] <= 1'b1;
		repeat (k) @(posedge pclk);
		ev <= 5'h00;
		@(posedge pclk);
	endtask

	task automatic finish_test;
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Monitor: oldest note against each answer
	always @(posedge pclk) begin
		if (pready === 1'b1)
			check({pslverr, prdata}, exp_q.pop_front());
	end

	// Watchdog
	initial begin
		repeat (95000) @(posedge pclk);
		error_cnt++;
		finish_test();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		void'($urandom(32'h54122BC8));
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		// Low before high gives the reset snapshot
		for (int i = 1; i < 10; i += 2)
			rd(10'(`IDX_P0_BAD_LINES_HIGH + i), 8'h00);
		// Count, read high then low, then see the clear
		for (int s = 0; s < 5; s++) begin
			n = $urandom_range(1000, 200);
			burst(s, n);
			rd(10'(`IDX_P0_BAD_LINES_HIGH + 2 * s), n[15:8]);
			rd(10'(`IDX_P0_BAD_LINES_HIGH + 2 * s + 1), n[7:0]);
			rd(10'(`IDX_P0_BAD_LINES_HIGH + 2 * s), 8'h00);
			rd(10'(`IDX_P0_BAD_LINES_HIGH + 2 * s + 1), 8'h00);
		end
		// Unmapped read and counter write are refused
		apb(1'b0, 10'h0A0, 32'h00000000, {1'b1, 32'h00000000});
		apb(1'b1, `IDX_P1_FRAMES_HIGH, 32'h000000FF, {1'b1, 32'h0});
		rd(`IDX_P1_FRAMES_HIGH, 8'h00);
		// Wrap raises a masked status, then unmask, clear
		burst(0, 65538);
		check({32'h0, irq}, 33'h0);
		apb(1'b1, `IDX_IRQ_MASK, 32'h00000001, 33'h0);
		check({32'h0, irq}, 33'h1);
		rd(`IDX_IRQ_STATUS, 8'h01);
		check({32'h0, irq}, 33'h0);
		rd(`IDX_P0_BAD_LINES_HIGH, 8'h00);
		rd(`IDX_P0_BAD_LINES_LOW, 8'h02);
		finish_test();
	end
endmodule
`default_nettype wire
